// [hdl/general_timer_unit.sv]
// General timer unit: timers a, b and c with APB registers and eight I/O lines
//
// Summary of operation
// - Three 32-bit timers a, b, c, separate or linked internally.
// - Each timer steps at most once per module clock.
// - Timer a or b events can trigger timer c actions.
// - Timer c overflow or underflow can clock timer a or b.
// - Timer b can count timer a carries, forming one 64-bit counter.
// - Timers a and b reload from their reload register on overflow.
// - Timers a and b split into 8/16/24-bit sub-timers with own reloads.
// - A and b overflows feed service requests, output pins and timer c.
// - Input pin levels or edges can set how timer a counts; only pin edges for timer b.
// - Timer c counts up or down, by software or external direction.
// - Timer c has timer, event counter and quadrature modes.
// - Timer c: external start/stop, one-shot, clear on external event.
// - Timer c owns two 32-bit reload/capture registers.
// - Timer c reloads on overflow or underflow.
// - Timer c reloads on a rising, falling or either-edge event.
// - Timer c captures its count on a selected edge event.
// - Capture-and-clear captures then zeroes timer c.
// - Timer c splits into two independent 16-bit counters.
// - Timer c functions take pin events or a/b overflows.
// - Timer c wraps clock a/b and toggle output pins.
// - Timer c overflow, underflow, capture and reload events can be routed to any service request.
// - Eight I/O lines carry inputs; only the lower four carry outputs.
`timescale 1ns/1ps
module general_timer_unit
  import timer_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic [7:0] io_oe,
  output logic [3:0] srq
);
  typedef struct packed {
    logic [31:0] ctrl_ab;
    logic [31:0] reload_a;
    logic [31:0] reload_b;
    logic [31:0] ctrl_c;
    logic [31:0] evsel;
    logic [31:0] count_c;
    logic [31:0] rc0;
    logic [31:0] rc1;
    logic [23:0] srq_route;
    logic [3:0] out_en;
    logic [3:0] out_lvl;
    logic quad_err;
    logic c_run;
    logic c_wrap;
    logic [7:0] io_prev;
    logic [3:0] srq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } unit_state_t;

  unit_state_t st_reg;
  unit_state_t st_next;

  logic acc;
  logic wr;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [15:0] ev;
  logic a_inc;
  logic b_inc;
  logic [31:0] count_a;
  logic [31:0] count_b;
  logic [3:0] a_seg;
  logic [3:0] b_seg;
  logic a_ovf;
  logic b_ovf;
  c_mode_t mode;
  logic run_eff;
  logic up;
  logic step;
  logic q_chg_a;
  logic q_chg_b;
  logic q_step;
  logic q_up;
  logic split;
  logic lo_ovf;
  logic lo_unf;
  logic hi_ovf;
  logic c_ovf;
  logic c_unf;
  logic c_rld;
  logic c_cap;
  logic c_clr;
  logic [5:0] srq_ev;

  assign acc = psel & penable;
  assign wr = acc & pwrite & st_reg.pready;

  // ************************************************************
  // Input edges and event selection
  // ************************************************************
  assign rise = io_in & ~st_reg.io_prev;
  assign fall = ~io_in & st_reg.io_prev;

  always_comb
  begin
    ev = '0;
    for (int k = 0; k < 4; k++)
    begin
      ev[1 + 3*k] = rise[4 + k];
      ev[2 + 3*k] = fall[4 + k];
      ev[3 + 3*k] = rise[4 + k] | fall[4 + k];
    end
    ev[13] = a_ovf;
    ev[14] = b_ovf;
    ev[15] = a_ovf | b_ovf;
  end

  // ************************************************************
  // Timers a and b
  // ************************************************************
  always_comb
  begin
    a_inc = 1'b0;
    b_inc = 1'b0;
    unique case (ab_src_t'(st_reg.ctrl_ab[A_SRC +: 2]))
      SRC_CLK: a_inc = 1'b1;
      SRC_CWRAP: a_inc = st_reg.c_wrap;
      SRC_PIN_EDGE: a_inc = rise[0];
      SRC_ALT: a_inc = io_in[0];
    endcase
    unique case (ab_src_t'(st_reg.ctrl_ab[B_SRC +: 2]))
      SRC_CLK: b_inc = 1'b1;
      SRC_CWRAP: b_inc = st_reg.c_wrap;
      SRC_PIN_EDGE: b_inc = rise[1];
      SRC_ALT: b_inc = a_ovf;
    endcase
    a_inc = a_inc & st_reg.ctrl_ab[A_RUN];
    b_inc = b_inc & st_reg.ctrl_ab[B_RUN];
  end

  split_timer #(
    .WIDTH(32)
  ) u_timer_a (
    .pclk(pclk),
    .presetn(presetn),
    .inc(a_inc),
    .brk(st_reg.ctrl_ab[A_BRK +: 3]),
    .reload(st_reg.reload_a),
    .load_en(wr && paddr == OFF_COUNT_A),
    .load_val(pwdata),
    .count(count_a),
    .seg_ovf(a_seg),
    .ovf()
  );

  split_timer #(
    .WIDTH(32)
  ) u_timer_b (
    .pclk(pclk),
    .presetn(presetn),
    .inc(b_inc),
    .brk(st_reg.ctrl_ab[B_BRK +: 3]),
    .reload(st_reg.reload_b),
    .load_en(wr && paddr == OFF_COUNT_B),
    .load_val(pwdata),
    .count(count_b),
    .seg_ovf(b_seg),
    .ovf()
  );

  assign a_ovf = |a_seg;
  assign b_ovf = |b_seg;

  // ************************************************************
  // Timer c stepping
  // ************************************************************
  assign mode = c_mode_t'(st_reg.ctrl_c[C_MODE +: 2]);
  assign split = st_reg.ctrl_c[C_SPLIT];
  assign run_eff = st_reg.c_run & (~st_reg.ctrl_c[C_EXT_RUN] | io_in[5]);
  assign q_chg_a = io_in[2] ^ st_reg.io_prev[2];
  assign q_chg_b = io_in[3] ^ st_reg.io_prev[3];
  assign q_step = q_chg_a ^ q_chg_b;
  assign q_up = io_in[2] ^ st_reg.io_prev[3];

  always_comb
  begin
    step = 1'b0;
    unique case (mode)
      MODE_TIMER: step = run_eff;
      MODE_COUNTER: step = run_eff & ev[st_reg.evsel[EV_CNT +: 4]];
      MODE_QUAD: step = run_eff & q_step;
      MODE_RSVD: step = 1'b0;
    endcase
    if (mode == MODE_QUAD)
    begin
      up = q_up;
    end
    else if (st_reg.ctrl_c[C_DIR_EXT])
    begin
      up = io_in[4];
    end
    else
    begin
      up = st_reg.ctrl_c[C_DIR_SW];
    end
  end

  assign lo_ovf = step & up & (split ? st_reg.count_c[15:0] == 16'hffff
    : st_reg.count_c == 32'hffff_ffff);
  assign lo_unf = step & ~up & (split ? st_reg.count_c[15:0] == 16'h0000
    : st_reg.count_c == 32'h0000_0000);
  assign hi_ovf = split & run_eff & (st_reg.count_c[31:16] == 16'hffff);
  assign c_ovf = lo_ovf | hi_ovf;
  assign c_unf = lo_unf;
  assign c_rld = ev[st_reg.evsel[EV_RLD +: 4]];
  assign c_cap = ev[st_reg.evsel[EV_CAP +: 4]];
  assign c_clr = ev[st_reg.evsel[EV_CLR +: 4]];
  assign srq_ev = {c_rld, c_cap, c_unf, c_ovf, b_ovf, a_ovf};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.io_prev = io_in;
    st_next.c_wrap = c_ovf | c_unf;
    // Timer c count
    if (split)
    begin
      if (lo_ovf | lo_unf)
      begin
        st_next.count_c[15:0] = st_reg.ctrl_c[C_RL_OVF] ? st_reg.rc0[15:0]
          : (up ? 16'h0000 : 16'hffff);
      end
      else if (step)
      begin
        st_next.count_c[15:0] = up ? st_reg.count_c[15:0] + 16'h0001
          : st_reg.count_c[15:0] - 16'h0001;
      end
      if (hi_ovf && st_reg.ctrl_c[C_RL_OVF])
      begin
        st_next.count_c[31:16] = st_reg.rc0[31:16];
      end
      else if (run_eff)
      begin
        st_next.count_c[31:16] = st_reg.count_c[31:16] + 16'h0001;
      end
    end
    else if ((lo_ovf | lo_unf) && st_reg.ctrl_c[C_RL_OVF])
    begin
      st_next.count_c = st_reg.rc0;
    end
    else if (step)
    begin
      st_next.count_c = up ? st_reg.count_c + 32'h0000_0001
        : st_reg.count_c - 32'h0000_0001;
    end
    if (c_rld)
    begin
      st_next.count_c = st_reg.ctrl_c[C_RLD_SRC] ? st_reg.rc1 : st_reg.rc0;
    end
    if (c_cap)
    begin
      if (st_reg.ctrl_c[C_CAP_DST])
      begin
        st_next.rc0 = st_reg.count_c;
      end
      else
      begin
        st_next.rc1 = st_reg.count_c;
      end
      if (st_reg.evsel[EV_CAPCLR])
      begin
        st_next.count_c = RST_COUNT;
      end
    end
    if (c_clr)
    begin
      st_next.count_c = RST_COUNT;
    end
    // Run flag: start event sets, one-shot wrap clears
    if (st_reg.ctrl_c[C_ONESHOT] && (c_ovf || c_unf))
    begin
      st_next.c_run = 1'b0;
    end
    if (ev[st_reg.evsel[EV_START +: 4]])
    begin
      st_next.c_run = 1'b1;
    end
    // Output toggles and service requests
    st_next.out_lvl = st_reg.out_lvl ^ {c_unf, c_ovf, b_ovf, a_ovf};
    for (int i = 0; i < 4; i++)
    begin
      st_next.srq[i] = |(st_reg.srq_route[SRQ_EVENTS*i +: SRQ_EVENTS] & srq_ev);
    end
    // Register writes
    if (wr)
    begin
      unique case (paddr)
        OFF_CTRL_AB: st_next.ctrl_ab = pwdata;
        OFF_RELOAD_A: st_next.reload_a = pwdata;
        OFF_RELOAD_B: st_next.reload_b = pwdata;
        OFF_CTRL_C:
        begin
          st_next.ctrl_c = pwdata;
          st_next.c_run = pwdata[C_RUN];
        end
        OFF_EVSEL_C: st_next.evsel = pwdata;
        OFF_COUNT_C: st_next.count_c = pwdata;
        OFF_RC0: st_next.rc0 = pwdata;
        OFF_RC1: st_next.rc1 = pwdata;
        OFF_OUT_EN: st_next.out_en = pwdata[3:0];
        OFF_SRQ_ROUTE: st_next.srq_route = pwdata[23:0];
        OFF_STATUS: st_next.quad_err = st_reg.quad_err & ~pwdata[ST_QERR];
        default: st_next.pslverr = st_reg.pslverr;
      endcase
    end
    if (mode == MODE_QUAD && q_chg_a && q_chg_b)
    begin
      st_next.quad_err = 1'b1;
    end
    // Bus answer: one wait state, then data and error
    st_next.pready = acc & ~st_reg.pready;
    st_next.pslverr = 1'b0;
    if (acc && !st_reg.pready)
    begin
      st_next.prdata = 32'h0000_0000;
      unique case (paddr)
        OFF_CTRL_AB: st_next.prdata = st_reg.ctrl_ab;
        OFF_RELOAD_A: st_next.prdata = st_reg.reload_a;
        OFF_RELOAD_B: st_next.prdata = st_reg.reload_b;
        OFF_COUNT_A: st_next.prdata = count_a;
        OFF_COUNT_B: st_next.prdata = count_b;
        OFF_CTRL_C:
        begin
          st_next.prdata = st_reg.ctrl_c;
          st_next.prdata[C_RUN] = st_reg.c_run;
        end
        OFF_EVSEL_C: st_next.prdata = st_reg.evsel;
        OFF_COUNT_C: st_next.prdata = st_reg.count_c;
        OFF_RC0: st_next.prdata = st_reg.rc0;
        OFF_RC1: st_next.prdata = st_reg.rc1;
        OFF_OUT_EN: st_next.prdata[3:0] = st_reg.out_en;
        OFF_SRQ_ROUTE: st_next.prdata[23:0] = st_reg.srq_route;
        OFF_STATUS:
        begin
          st_next.prdata[ST_QERR] = st_reg.quad_err;
          st_next.prdata[ST_DIR] = up;
          st_next.prdata[ST_RUN] = st_reg.c_run;
        end
        default: st_next.pslverr = 1'b1;
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '{ctrl_ab: RST_CTRL, reload_a: RST_RELOAD, reload_b: RST_RELOAD,
        ctrl_c: RST_CTRL, evsel: RST_CTRL, count_c: RST_COUNT, rc0: RST_RELOAD,
        rc1: RST_RELOAD, srq_route: 24'h00_0000, out_en: 4'h0, out_lvl: 4'h0,
        quad_err: 1'b0, c_run: 1'b0, c_wrap: 1'b0, io_prev: 8'h00, srq: 4'h0,
        prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign io_out = {4'h0, st_reg.out_lvl};
  assign io_oe = {4'h0, st_reg.out_en};
  assign srq = st_reg.srq;
endmodule

// [inc/timer_unit_pkg.sv]
// Shared constants of the general timer unit: register map, fields, resets, codes
package timer_unit_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CTRL_AB = 8'h00;
  localparam logic [7:0] OFF_RELOAD_A = 8'h04;
  localparam logic [7:0] OFF_RELOAD_B = 8'h08;
  localparam logic [7:0] OFF_COUNT_A = 8'h0c;
  localparam logic [7:0] OFF_COUNT_B = 8'h10;
  localparam logic [7:0] OFF_CTRL_C = 8'h14;
  localparam logic [7:0] OFF_EVSEL_C = 8'h18;
  localparam logic [7:0] OFF_COUNT_C = 8'h1c;
  localparam logic [7:0] OFF_RC0 = 8'h20;
  localparam logic [7:0] OFF_RC1 = 8'h24;
  localparam logic [7:0] OFF_OUT_EN = 8'h28;
  localparam logic [7:0] OFF_SRQ_ROUTE = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int A_RUN = 0;
  localparam int A_SRC = 1;
  localparam int A_BRK = 3;
  localparam int B_RUN = 8;
  localparam int B_SRC = 9;
  localparam int B_BRK = 11;
  localparam int C_MODE = 0;
  localparam int C_DIR_SW = 2;
  localparam int C_DIR_EXT = 3;
  localparam int C_RUN = 4;
  localparam int C_EXT_RUN = 5;
  localparam int C_ONESHOT = 6;
  localparam int C_SPLIT = 7;
  localparam int C_RL_OVF = 8;
  localparam int C_CAP_DST = 9;
  localparam int C_RLD_SRC = 10;
  localparam int EV_CNT = 0;
  localparam int EV_RLD = 4;
  localparam int EV_CAP = 8;
  localparam int EV_CLR = 12;
  localparam int EV_START = 16;
  localparam int EV_CAPCLR = 20;
  localparam int ST_QERR = 0;
  localparam int ST_DIR = 1;
  localparam int ST_RUN = 2;
  localparam int SRQ_EVENTS = 6;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] RST_RELOAD = 32'h0000_0000;
  // ************************************************************
  // Codes
  // ************************************************************
  typedef enum logic [1:0] {SRC_CLK = 2'b00, SRC_CWRAP = 2'b01, SRC_PIN_EDGE = 2'b10,
    SRC_ALT = 2'b11} ab_src_t;
  typedef enum logic [1:0] {MODE_TIMER = 2'b00, MODE_COUNTER = 2'b01, MODE_QUAD = 2'b10,
    MODE_RSVD = 2'b11} c_mode_t;
endpackage

// [hdl/split_timer.sv]
// Reloading 32-bit timer that can be cut into 8-, 16- or 24-bit sub-timers
`timescale 1ns/1ps
module split_timer
  import timer_unit_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic inc,
  input wire logic [2:0] brk,
  input wire logic [31:0] reload,
  input wire logic load_en,
  input wire logic [31:0] load_val,
  output logic [31:0] count,
  output logic [3:0] seg_ovf,
  output logic ovf
);
  typedef struct packed {
    logic [31:0] cnt;
  } tstate_t;

  tstate_t st_reg;
  tstate_t st_next;
  logic [4:0] carry;
  logic [3:0] co;
  logic [3:0] seg_end;
  logic [3:0] rl;

  if (WIDTH != 32)
  begin : g_chk
    $error("split_timer supports only a 32-bit width");
  end

  // ************************************************************
  // Byte carry chain with break points
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    carry = '0;
    co = '0;
    seg_end = '0;
    rl = '0;
    // Top byte always closes a segment; a break bit starts a fresh sub-timer above it
    seg_end = {1'b1, brk};
    carry[0] = inc;
    for (int i = 0; i < 4; i++)
    begin
      co[i] = carry[i] & (st_reg.cnt[8*i +: 8] == 8'hff);
      carry[i+1] = seg_end[i] ? inc : co[i];
    end
    rl[3] = co[3];
    for (int i = 2; i >= 0; i--)
    begin
      rl[i] = seg_end[i] ? co[i] : rl[i+1];
    end
    for (int i = 0; i < 4; i++)
    begin
      if (rl[i])
      begin
        st_next.cnt[8*i +: 8] = reload[8*i +: 8];
      end
      else if (carry[i])
      begin
        st_next.cnt[8*i +: 8] = st_reg.cnt[8*i +: 8] + 8'h01;
      end
    end
    if (load_en)
    begin
      st_next.cnt = load_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '{cnt: RST_COUNT};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;
  assign seg_ovf = co & seg_end;
  assign ovf = co[3];
endmodule

// [tb/general_timer_unit_monitor.sv]
// Bus handshake and pin line checker for the general timer unit
`timescale 1ns/1ps
module general_timer_unit_monitor
  import timer_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] io_in,
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  input wire logic [3:0] srq
);
  // ****
  // Helper logic
  // ****
  logic done;
  logic [23:0] route_reg;
  assign done = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      route_reg <= 24'h0;
    else if (done && pwrite && paddr == OFF_SRQ_ROUTE)
      route_reg <= pwdata[23:0];
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    (psel && penable && !pready) ##1 (psel && penable && pready);
  endsequence
  AST_PREADY_WAIT: assert property (setup_s |=> access_s)
    else $error("pready not in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_SHAPE: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  AST_UNMAPPED_ERR: assert property (done && paddr > OFF_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (done && paddr <= OFF_STATUS && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  AST_IDLE_LINES: assert property (io_out[7:4] == 4'h0 && io_oe[7:4] == 4'h0)
    else $error("upper lines active");
  AST_OE_WRITE: assert property (done && pwrite && paddr == OFF_OUT_EN |=>
    io_oe[3:0] == $past(pwdata[3:0]))
    else $error("output enable not updated");
  AST_OE_READ: assert property (done && !pwrite && paddr == OFF_OUT_EN |->
    prdata[3:0] == io_oe[3:0])
    else $error("output enable readback wrong");
  AST_SRQ_ROUTED: assert property ($stable(route_reg) && route_reg == 24'h0 |->
    srq == 4'h0)
    else $error("service request without route");
endmodule

bind general_timer_unit general_timer_unit_monitor u_general_timer_unit_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .srq(srq));

// [tb/pin_model.sv]
// Behavioural model of the external event and encoder lines
`timescale 1ns/1ps
module pin_model
(
  input wire logic pclk,
  output logic [7:0] io_in
);
  initial io_in = 8'h00;
  // Lines move just after an edge and stay put for three cycles
  task automatic drive(input int p, input logic v);
    @(posedge pclk);
    io_in[p] <= v;
    repeat (2) @(posedge pclk);
  endtask
  task automatic pulse(input int p);
    drive(p, 1'b1);
    drive(p, 1'b0);
  endtask
  task automatic quad(input logic [1:0] ba);
    @(posedge pclk);
    io_in[3:2] <= ba;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// [tb/test_general_timer_unit.sv]
// Register and pin level test of the general timer unit
`timescale 1ns/1ps
module test_general_timer_unit
  import timer_unit_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic rerr;
  logic [7:0] paddr;
  logic [7:0] io_in;
  logic [7:0] io_out;
  logic [7:0] io_oe;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic [3:0] srq;
  int failures;
  int cmp_count;
  general_timer_unit u_general_timer_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .srq(srq));
  pin_model u_pin_model (.pclk(pclk), .io_in(io_in));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // Tasks
  // ****
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rdata, exp);
  endtask
  task automatic see_srq();
    logic hit;
    hit = 1'b0;
    repeat (12)
    begin
      @(posedge pclk);
      if (srq[0] === 1'b1)
        hit = 1'b1;
    end
    chk("srq0", {31'h0, hit}, 32'h1);
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl_ab", OFF_CTRL_AB, RST_CTRL);
    rd("count_c", OFF_COUNT_C, RST_COUNT);
    rd("rc1", OFF_RC1, RST_RELOAD);
    xfer(1'b0, 8'h34, 32'h0);
    chk("unmapped rd", {rerr, rdata[30:0]}, 32'h8000_0000);
    wr(8'h40, 32'hffff_ffff);
    chk("unmapped wr", {31'h0, rerr}, 32'h1);
    wr(OFF_RELOAD_A, 32'h0000_0010);
    wr(OFF_COUNT_A, 32'hffff_fffe);
    wr(OFF_OUT_EN, 32'h0000_000f);
    wr(OFF_CTRL_AB, 32'h0000_0705);
    repeat (3) u_pin_model.pulse(0);
    rd("count_a", OFF_COUNT_A, 32'h0000_0011);
    rd("count_b", OFF_COUNT_B, 32'h0000_0001);
    chk("lines", {16'h0, io_oe, io_out}, 32'h0000_0f01);
    wr(OFF_RELOAD_A, 32'h1234_5678);
    wr(OFF_COUNT_A, 32'h0000_01ff);
    wr(OFF_CTRL_AB, 32'h0000_000d);
    u_pin_model.pulse(0);
    rd("split a", OFF_COUNT_A, 32'h0000_0278);
    wr(OFF_EVSEL_C, 32'h0000_0001);
    wr(OFF_CTRL_C, 32'h0000_0015);
    repeat (3) u_pin_model.pulse(4);
    rd("c up", OFF_COUNT_C, 32'h0000_0003);
    wr(OFF_CTRL_C, 32'h0000_0011);
    u_pin_model.pulse(4);
    rd("c down", OFF_COUNT_C, 32'h0000_0002);
    wr(OFF_RC0, 32'h0000_0055);
    wr(OFF_EVSEL_C, 32'h0000_0051);
    u_pin_model.drive(5, 1'b1);
    rd("rise kept", OFF_COUNT_C, 32'h0000_0002);
    u_pin_model.drive(5, 1'b0);
    rd("fall reload", OFF_COUNT_C, 32'h0000_0055);
    wr(OFF_SRQ_ROUTE, 32'h0000_0010);
    wr(OFF_EVSEL_C, 32'h0010_0701);
    wr(OFF_CTRL_C, 32'h0000_0215);
    u_pin_model.pulse(4);
    fork
      u_pin_model.pulse(6);
      see_srq();
    join
    rd("capture", OFF_RC0, 32'h0000_0056);
    rd("cleared", OFF_COUNT_C, 32'h0000_0000);
    wr(OFF_CTRL_C, 32'h0000_0012);
    u_pin_model.quad(2'b01);
    u_pin_model.quad(2'b11);
    u_pin_model.quad(2'b10);
    u_pin_model.quad(2'b00);
    rd("quad", OFF_COUNT_C, 32'h0000_0004);
    u_pin_model.quad(2'b11);
    rd("quad skip", OFF_COUNT_C, 32'h0000_0004);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("quad err", {31'h0, rdata[ST_QERR]}, 32'h1);
    wr(OFF_STATUS, 32'h0000_0001);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("err clear", {31'h0, rdata[ST_QERR]}, 32'h0);
    // Timer b on its pin edge, timer a on timer c wraps
    wr(OFF_CTRL_AB, 32'h0000_0503);
    u_pin_model.pulse(1);
    rd("b pin", OFF_COUNT_B, 32'h0000_0002);
    // Stopped counter started by a pin 7 event
    wr(OFF_COUNT_C, 32'h0000_0000);
    wr(OFF_EVSEL_C, 32'h000a_0001);
    wr(OFF_CTRL_C, 32'h0000_0005);
    u_pin_model.pulse(4);
    u_pin_model.pulse(7);
    u_pin_model.pulse(4);
    rd("start", OFF_COUNT_C, 32'h0000_0001);
    // External down count, reload on underflow, one-shot stop
    wr(OFF_EVSEL_C, 32'h0000_000a);
    wr(OFF_CTRL_C, 32'h0000_0159);
    repeat (3) u_pin_model.pulse(7);
    rd("unf reload", OFF_COUNT_C, 32'h0000_0056);
    rd("c wrap a", OFF_COUNT_A, 32'h0000_0279);
    chk("toggle", {16'h0, io_oe, io_out}, 32'h0000_0f08);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("one-shot", rdata, 32'h0000_0000);
    conclude();
  end
endmodule
